//--- dpr_defines.vh
`ifndef DPR_DEFINES_VH
`define DPR_DEFINES_VH

// Port address width, enough for 16K x 1
`define DPR_AW 14
// Data and parity lanes of one stored word
`define DPR_DW 32
`define DPR_PW 4
`define DPR_WW 36
// Word index width and depth: 512 words of 36 bits, 18 Kb in all
`define DPR_WIDX_W 9
`define DPR_DEPTH 512
// Bits of one synchronised port bundle
`define DPR_BUNDLE_W 54

// Aspect ratio codes; the code is log2 of the data width
`define DPR_MODE_X1 0
`define DPR_MODE_X2 1
`define DPR_MODE_X4 2
`define DPR_MODE_X9 3
`define DPR_MODE_X18 4
`define DPR_MODE_X36 5
// First code that carries parity
`define DPR_MODE_PAR 3

// Read data behaviour on a write by the same port
`define DPR_WM_READ_FIRST 0
`define DPR_WM_WRITE_FIRST 1
`define DPR_WM_NO_CHANGE 2

// Output register value after rst_i
`define DPR_OUT_RST 36'h000000000

`endif

//--- dpr_port.v
`timescale 1ns/1ps
`include "dpr_defines.vh"

module dpr_port #(
  parameter [0:0] CLK_INV = 1'b0,
  parameter [0:0] EN_INV = 1'b0,
  parameter [0:0] WE_INV = 1'b0,
  parameter [0:0] SSR_INV = 1'b0
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire port_clk_i,
  input wire en_i,
  input wire we_i,
  input wire sync_set_reset_in_i,
  input wire [`DPR_AW-1:0] addr_i,
  input wire [`DPR_DW-1:0] wdata_i,
  input wire [`DPR_PW-1:0] wpar_i,
  output wire req_o,
  output wire we_o,
  output wire ssr_o,
  output wire [`DPR_AW-1:0] addr_o,
  output wire [`DPR_DW-1:0] wdata_o,
  output wire [`DPR_PW-1:0] wpar_o
);

  reg [`DPR_BUNDLE_W-1:0] meta_q;
  reg [`DPR_BUNDLE_W-1:0] sync_q;
  reg clk_prev_q;
  wire [`DPR_BUNDLE_W-1:0] bundle;
  wire clk_now;
  wire rise;
  wire fall;
  wire edge_act;

  assign bundle = {port_clk_i, en_i, we_i, sync_set_reset_in_i,
                   addr_i, wdata_i, wpar_i};

  //////////////////////////////////////////////////////////////////////////
  // Two-stage capture of the whole pin bundle, clock included
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_q <= {`DPR_BUNDLE_W{1'b0}};
      sync_q <= {`DPR_BUNDLE_W{1'b0}};
      clk_prev_q <= 1'b0;
    end else if (ce_i) begin
      meta_q <= bundle;
      sync_q <= meta_q;
      clk_prev_q <= sync_q[`DPR_BUNDLE_W-1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Active edge and control polarity chosen statically
  assign clk_now = sync_q[`DPR_BUNDLE_W-1];
  assign rise = clk_now & ~clk_prev_q;
  assign fall = ~clk_now & clk_prev_q;
  assign edge_act = CLK_INV ? fall : rise; // RQ3 RQ5
  // Disabled edges give no request at all
  assign req_o = edge_act & (sync_q[52] ^ EN_INV); // RQ3 RQ11
  assign we_o = sync_q[51] ^ WE_INV; // RQ3
  assign ssr_o = sync_q[50] ^ SSR_INV; // RQ3
  assign addr_o = sync_q[49:36]; // RQ5
  assign wdata_o = sync_q[35:4]; // RQ5
  assign wpar_o = sync_q[3:0]; // RQ5

endmodule // dpr_port

//--- dpr_top.v
`timescale 1ns/1ps
`include "dpr_defines.vh"

// Notes on behaviour
// RQ1: 18 Kb shared by two concurrent ports
// RQ2: Both ports behave identically; the code gives B priority when both write one word
// RQ3: Clock, enable, write, reset polarities configurable
// RQ4: Each port: controls, write bus, read bus
// RQ5: Inputs sampled only at active port edge
// RQ6: Read outputs registered on same edge
// RQ7: Six aspect ratios from 16Kx1 to 512x36
// RQ8: Narrow widths reach 16 Kb, no parity
// RQ9: One parity bit per data byte
// RQ10: User logic generates and checks parity
// RQ11: Disabled edge does nothing, output holds
// RQ12: Set/reset loads output, memory untouched
module dpr_top #(
  parameter [2:0] A_MODE = 3'h5,
  parameter [2:0] B_MODE = 3'h5,
  parameter [1:0] A_WMODE = 2'h0,
  parameter [1:0] B_WMODE = 2'h0,
  parameter [0:0] A_CLK_INV = 1'b0,
  parameter [0:0] B_CLK_INV = 1'b0,
  parameter [0:0] A_EN_INV = 1'b0,
  parameter [0:0] B_EN_INV = 1'b0,
  parameter [0:0] A_WE_INV = 1'b0,
  parameter [0:0] B_WE_INV = 1'b0,
  parameter [0:0] A_SSR_INV = 1'b0,
  parameter [0:0] B_SSR_INV = 1'b0,
  parameter [35:0] A_SRVAL = 36'h000000000,
  parameter [35:0] B_SRVAL = 36'h000000000
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire a_port_clk_i,
  input wire a_en_i,
  input wire a_we_i,
  input wire a_sync_set_reset_in_i,
  input wire [`DPR_AW-1:0] a_addr_i,
  input wire [`DPR_DW-1:0] a_wdata_i,
  input wire [`DPR_PW-1:0] a_wpar_i,
  output wire [`DPR_DW-1:0] a_rdata_o,
  output wire [`DPR_PW-1:0] a_rpar_o,
  input wire b_port_clk_i,
  input wire b_en_i,
  input wire b_we_i,
  input wire b_sync_set_reset_in_i,
  input wire [`DPR_AW-1:0] b_addr_i,
  input wire [`DPR_DW-1:0] b_wdata_i,
  input wire [`DPR_PW-1:0] b_wpar_i,
  output wire [`DPR_DW-1:0] b_rdata_o,
  output wire [`DPR_PW-1:0] b_rpar_o,
  output wire collision_o
);

  // Per-port pins gathered so one generate loop serves both ports
  wire [1:0] pin_clk;
  wire [1:0] pin_en;
  wire [1:0] pin_we;
  wire [1:0] pin_ssr;
  wire [2*`DPR_AW-1:0] pin_addr;
  wire [2*`DPR_DW-1:0] pin_wdata;
  wire [2*`DPR_PW-1:0] pin_wpar;

  // Decoded requests
  wire [1:0] req;
  wire [1:0] wr;
  wire [1:0] sync_set_reset_in;
  wire [2*`DPR_WIDX_W-1:0] widx;
  wire [2*`DPR_WW-1:0] wmask;
  wire [2*`DPR_WW-1:0] wword;
  wire [2*`DPR_WW-1:0] newword;
  wire [2*`DPR_WW-1:0] rdout;

  reg [`DPR_WW-1:0] mem_q [0:`DPR_DEPTH-1];
  reg [`DPR_WW-1:0] new0;
  reg [`DPR_WW-1:0] base1;
  reg [`DPR_WW-1:0] new1;
  reg collision_q;
  wire same_word;

  assign pin_clk = {b_port_clk_i, a_port_clk_i};
  assign pin_en = {b_en_i, a_en_i};
  assign pin_we = {b_we_i, a_we_i};
  assign pin_ssr = {b_sync_set_reset_in_i, a_sync_set_reset_in_i};
  assign pin_addr = {b_addr_i, a_addr_i};
  assign pin_wdata = {b_wdata_i, a_wdata_i};
  assign pin_wpar = {b_wpar_i, a_wpar_i};

  assign a_rdata_o = rdout[31:0];
  assign a_rpar_o = rdout[35:32];
  assign b_rdata_o = rdout[67:36];
  assign b_rpar_o = rdout[71:68];
  assign collision_o = collision_q;

  //////////////////////////////////////////////////////////////////////////
  // One identical port slice per side
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_port // RQ2
      localparam integer MODE = (g == 0) ? A_MODE : B_MODE;
      localparam integer WMODE = (g == 0) ? A_WMODE : B_WMODE;
      localparam [35:0] SRVAL = (g == 0) ? A_SRVAL : B_SRVAL;
      localparam integer LB = 5 - MODE;
      localparam integer PS = (MODE >= `DPR_MODE_PAR) ? MODE - 3 : 0;
      // Data lane mask at the bottom of the word
      localparam [31:0] DBASE = (MODE == `DPR_MODE_X36) ? 32'hFFFFFFFF :
                                ((32'h1 << (1 << MODE)) - 32'h1); // RQ7
      // Parity only in the byte-wide modes
      localparam [3:0] PBASE = (MODE == `DPR_MODE_X9) ? 4'h1 :
                               (MODE == `DPR_MODE_X18) ? 4'h3 :
                               (MODE == `DPR_MODE_X36) ? 4'hF :
                               4'h0; // RQ8 RQ9

      wire p_req;
      wire p_we;
      wire p_ssr;
      wire [`DPR_AW-1:0] p_addr;
      wire [`DPR_DW-1:0] p_wdata;
      wire [`DPR_PW-1:0] p_wpar;
      wire [`DPR_AW-1:0] word_full;
      wire [`DPR_AW-1:0] lane_full;
      wire [31:0] doff;
      wire [31:0] poff;
      wire [31:0] dmask;
      wire [3:0] pmask;
      wire [31:0] wd;
      wire [3:0] wp;
      wire [35:0] rword;
      wire [31:0] rd_sh;
      wire [3:0] rp_sh;
      reg [35:0] out_q;

      dpr_port #(
        .CLK_INV((g == 0) ? A_CLK_INV : B_CLK_INV),
        .EN_INV((g == 0) ? A_EN_INV : B_EN_INV),
        .WE_INV((g == 0) ? A_WE_INV : B_WE_INV),
        .SSR_INV((g == 0) ? A_SSR_INV : B_SSR_INV)
      ) u_port (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .port_clk_i(pin_clk[g]),
        .en_i(pin_en[g]),
        .we_i(pin_we[g]),
        .sync_set_reset_in_i(pin_ssr[g]),
        .addr_i(pin_addr[g*`DPR_AW +: `DPR_AW]),
        .wdata_i(pin_wdata[g*`DPR_DW +: `DPR_DW]),
        .wpar_i(pin_wpar[g*`DPR_PW +: `DPR_PW]),
        .req_o(p_req),
        .we_o(p_we),
        .ssr_o(p_ssr),
        .addr_o(p_addr),
        .wdata_o(p_wdata),
        .wpar_o(p_wpar)
      );

      // Word index and lane within the 36-bit word
      assign word_full = p_addr >> LB; // RQ7
      assign lane_full = p_addr & ((14'h0001 << LB) - 14'h0001);
      assign doff = {27'h0000000, lane_full[4:0]} << MODE;
      assign poff = {27'h0000000, lane_full[4:0]} << PS;
      assign dmask = DBASE << doff;
      assign pmask = PBASE << poff[1:0]; // RQ9
      assign wd = (p_wdata & DBASE) << doff;
      assign wp = (p_wpar & PBASE) << poff[1:0]; // RQ9 RQ10

      assign req[g] = p_req & ce_i; // RQ11
      assign wr[g] = p_req & ce_i & p_we;
      assign sync_set_reset_in[g] = p_ssr;
      assign widx[g*`DPR_WIDX_W +: `DPR_WIDX_W] = word_full[8:0];
      assign wmask[g*`DPR_WW +: `DPR_WW] = {pmask, dmask};
      assign wword[g*`DPR_WW +: `DPR_WW] = {wp, wd};

      // Own write shows on the output only in write-first mode
      assign rword = (WMODE == `DPR_WM_WRITE_FIRST && p_we) ?
                     newword[g*`DPR_WW +: `DPR_WW] :
                     mem_q[word_full[8:0]];
      assign rd_sh = (rword[31:0] >> doff) & DBASE;
      assign rp_sh = (rword[35:32] >> poff[1:0]) & PBASE; // RQ9

      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          out_q <= `DPR_OUT_RST;
        end else if (req[g]) begin // RQ11
          if (sync_set_reset_in[g]) begin
            out_q <= SRVAL; // RQ12
          end else if (!(WMODE == `DPR_WM_NO_CHANGE && p_we)) begin
            out_q <= {rp_sh, rd_sh}; // RQ6
          end
        end
      end

      assign rdout[g*`DPR_WW +: `DPR_WW] = out_q; // RQ4
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Shared array; on a common word both writes merge, B wins on overlap
  assign same_word = (widx[8:0] == widx[17:9]);

  always @* begin
    new0 = (mem_q[widx[8:0]] & ~wmask[35:0]) |
           (wword[35:0] & wmask[35:0]);
    base1 = (wr[0] && same_word) ? new0 : mem_q[widx[17:9]];
    new1 = (base1 & ~wmask[71:36]) | (wword[71:36] & wmask[71:36]);
  end

  assign newword = {new1, new0};

  // Set/reset never touches the array, writes go ahead regardless
  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (wr[0]) begin
        mem_q[widx[8:0]] <= new0; // RQ1 RQ12
      end
      if (wr[1]) begin
        mem_q[widx[17:9]] <= new1; // RQ1 RQ2
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Same word hit by both ports in one cycle with at least one writing
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      collision_q <= 1'b0;
    end else if (ce_i) begin
      collision_q <= req[0] & req[1] & same_word & (wr[0] | wr[1]);
    end
  end

endmodule // dpr_top

//--- dpr_top_asserts.sv
`timescale 1ns/1ps
`include "dpr_defines.vh"
module dpr_chk #(
  parameter [2:0] B_MODE = 3'h5,
  parameter [35:0] A_SRVAL = 36'h000000000
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire ce_i,
  input wire a_port_clk_i,
  input wire a_en_i,
  input wire a_we_i,
  input wire a_sync_set_reset_in_i,
  input wire b_port_clk_i,
  input wire b_en_i,
  input wire [`DPR_DW-1:0] a_rdata_o,
  input wire [`DPR_PW-1:0] a_rpar_o,
  input wire [`DPR_DW-1:0] b_rdata_o,
  input wire [`DPR_PW-1:0] b_rpar_o,
  input wire collision_o
);
  reg a1_q, a2_q, b1_q, b2_q;
  reg [2:0] aw_q, bw_q;
  wire a_req = a1_q & ~a2_q & a_en_i;
  wire b_req = b1_q & ~b2_q & b_en_i;
  // Shadow pin synchroniser; a window opens on each enabled edge
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      a1_q <= 1'h0;
      a2_q <= 1'h0;
      b1_q <= 1'h0;
      b2_q <= 1'h0;
      aw_q <= 3'h0;
      bw_q <= 3'h0;
    end else if (ce_i) begin
      a1_q <= a_port_clk_i;
      a2_q <= a1_q;
      b1_q <= b_port_clk_i;
      b2_q <= b1_q;
      aw_q <= a_req ? 3'h6 : aw_q - {2'h0, |aw_q};
      bw_q <= b_req ? 3'h6 : bw_q - {2'h0, |bw_q};
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_rst;
    disable iff (1'h0) (rst_i && ce_i) |=>
      (a_rdata_o == 32'h0 && b_rdata_o == 32'h0 && !collision_o);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_a_hold;
    $changed(a_rdata_o) |-> aw_q != 3'h0;
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("a moved idle");
  property p_b_hold;
    $changed(b_rdata_o) || $changed(b_rpar_o) |-> bw_q != 3'h0;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b moved idle");
  property p_lat;
    a_req && ce_i |-> ##1 $stable({a_rpar_o, a_rdata_o});
  endproperty
  a_lat: assert property (p_lat) else $error("a output early");
  property p_ssr;
    a_req && ce_i && a_sync_set_reset_in_i |->
      ##2 {a_rpar_o, a_rdata_o} == A_SRVAL;
  endproperty
  a_ssr: assert property (p_ssr) else $error("a set value wrong");
  property p_frz;
    !$past(ce_i) && !$past(rst_i) |-> $stable(a_rdata_o) && $stable(b_rdata_o);
  endproperty
  a_frz: assert property (p_frz) else $error("moved while frozen");
  property p_col;
    collision_o |=> !collision_o;
  endproperty
  a_col: assert property (p_col) else $error("collision too long");
  property p_lane;
    B_MODE == 3'h3 |-> b_rdata_o[31:8] == 24'h0 && b_rpar_o[3:1] == 3'h0;
  endproperty
  a_lane: assert property (p_lane) else $error("b lane bits set");
  c_wr: cover property (a_req && a_we_i);
  c_ssr: cover property (a_req && a_sync_set_reset_in_i);
  c_col: cover property (collision_o);
endmodule // dpr_chk
bind dpr_top dpr_chk #(.B_MODE(B_MODE), .A_SRVAL(A_SRVAL)) dpr_chk_inst (
  .clk_sys_i(clk_sys_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .a_port_clk_i(a_port_clk_i),
  .a_en_i(a_en_i),
  .a_we_i(a_we_i),
  .a_sync_set_reset_in_i(a_sync_set_reset_in_i),
  .b_port_clk_i(b_port_clk_i),
  .b_en_i(b_en_i),
  .a_rdata_o(a_rdata_o),
  .a_rpar_o(a_rpar_o),
  .b_rdata_o(b_rdata_o),
  .b_rpar_o(b_rpar_o),
  .collision_o(collision_o)
);

//--- dpr_user.sv
`timescale 1ns/1ps
module dpr_user (
  input wire clk_sys_i,
  output reg pclk_o = 1'h0,
  output reg en_o = 1'h0,
  output reg we_o = 1'h0,
  output reg ssr_o = 1'h0,
  output reg [13:0] addr_o = 14'h0,
  output reg [31:0] wdata_o = 32'h0,
  output reg [3:0] wpar_o = 4'h0
);
  // Idle: clock low, enable off, stale lines inverted
  task op(input e, input w, input s, input [13:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_i);
      pclk_o <= 1'h0;
      en_o <= 1'h0;
      addr_o <= ~addr_o;
      wdata_o <= ~wdata_o;
      repeat (3) @(posedge clk_sys_i);
      en_o <= e;
      we_o <= w;
      ssr_o <= s;
      addr_o <= a;
      wdata_o <= d;
      wpar_o <= {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
      repeat (3) @(posedge clk_sys_i);
      pclk_o <= 1'h1;
      repeat (4) @(posedge clk_sys_i);
    end
  endtask
endmodule // dpr_user

//--- dpr_top_tb.sv
`timescale 1ns/1ps
`include "dpr_defines.vh"
module dpr_top_tb;
  localparam [35:0] SRV = 36'h912345678;
  localparam [31:0] DW = 32'h12345678;
  localparam [31:0] W7 = 32'hA3A2A1A0;
  reg clk_sys_i = 1'h0;
  reg rst_i = 1'h1;
  reg ce_i = 1'h1;
  reg col_seen = 1'h0;
  integer error_cnt = 0;
  integer check_count = 0;
  integer n;
  wire a_pc, a_en, a_we, a_ss, b_pc, b_en, b_we, b_ss, col;
  wire [13:0] a_ad, b_ad;
  wire [31:0] a_wd, b_wd, a_rd, b_rd;
  wire [3:0] a_wp, b_wp, a_rp, b_rp;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (col) col_seen <= 1'h1;
  dpr_top #(.B_MODE(3'h3), .B_WMODE(2'h1), .A_SRVAL(SRV)) dpr_top_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .a_port_clk_i(a_pc), .a_en_i(a_en), .a_we_i(a_we),
    .a_sync_set_reset_in_i(a_ss), .a_addr_i(a_ad), .a_wdata_i(a_wd),
    .a_wpar_i(a_wp), .a_rdata_o(a_rd), .a_rpar_o(a_rp),
    .b_port_clk_i(b_pc), .b_en_i(b_en), .b_we_i(b_we),
    .b_sync_set_reset_in_i(b_ss), .b_addr_i(b_ad), .b_wdata_i(b_wd),
    .b_wpar_i(b_wp), .b_rdata_o(b_rd), .b_rpar_o(b_rp),
    .collision_o(col));
  dpr_user a_dpr_user_inst (.clk_sys_i(clk_sys_i), .pclk_o(a_pc),
    .en_o(a_en), .we_o(a_we), .ssr_o(a_ss), .addr_o(a_ad),
    .wdata_o(a_wd), .wpar_o(a_wp));
  dpr_user b_dpr_user_inst (.clk_sys_i(clk_sys_i), .pclk_o(b_pc),
    .en_o(b_en), .we_o(b_we), .ssr_o(b_ss), .addr_o(b_ad),
    .wdata_o(b_wd), .wpar_o(b_wp));
  function [3:0] par(input [31:0] d);
    par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction
  task check(input [35:0] seen, input [35:0] exp, input string nm);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      if (error_cnt == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Word written on A, read back on A and byte by byte on B
  task t_rw;
    begin
      a_dpr_user_inst.op(1'h1, 1'h1, 1'h0, 14'h5, DW);
      a_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'h5, 32'h0);
      #1 check({a_rp, a_rd}, {par(DW), DW}, "a word");
      for (n = 0; n < 4; n = n + 1) begin
        b_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'(20 + n), 32'h0);
        #1 check({b_rp, b_rd}, {3'h0, ^DW[8*n+:8], 24'h0, DW[8*n+:8]},
          "b byte");
      end
    end
  endtask
  task t_ce;
    begin
      @(posedge clk_sys_i) ce_i <= 1'h0;
      b_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'h14, 32'h0);
      #1 check({b_rp, b_rd}, {3'h0, ^DW[31:24], 24'h0, DW[31:24]},
        "b frozen");
      @(posedge clk_sys_i) ce_i <= 1'h1;
      // Edges made while frozen are lost; a fresh edge must work again
      b_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'h15, 32'h0);
      #1 check({b_rp, b_rd}, {3'h0, ^DW[15:8], 24'h0, DW[15:8]}, "b run");
    end
  endtask
  task t_bw;
    begin
      for (n = 0; n < 4; n = n + 1)
        b_dpr_user_inst.op(1'h1, 1'h1, 1'h0, 14'(28 + n), W7[8*n+:8]);
      // Port B is write-first: its own last byte shows on its output
      #1 check({b_rp, b_rd}, {3'h0, ^W7[31:24], 24'h0, W7[31:24]}, "b wfirst");
      a_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'h7, 32'h0);
      #1 check({a_rp, a_rd}, {par(W7), W7}, "a merged");
    end
  endtask
  task t_en;
    begin
      a_dpr_user_inst.op(1'h0, 1'h1, 1'h0, 14'h5, 32'hDEADBEEF);
      #1 check({a_rp, a_rd}, {par(W7), W7}, "a held");
      a_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'h5, 32'h0);
      #1 check({a_rp, a_rd}, {par(DW), DW}, "a kept");
    end
  endtask
  task t_ssr;
    begin
      a_dpr_user_inst.op(1'h1, 1'h0, 1'h1, 14'h5, 32'h0);
      #1 check({a_rp, a_rd}, SRV, "a set");
      a_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'h5, 32'h0);
      #1 check({a_rp, a_rd}, {par(DW), DW}, "a after set");
    end
  endtask
  task t_col;
    begin
      fork
        a_dpr_user_inst.op(1'h1, 1'h1, 1'h0, 14'h3, 32'h0F0F0F0F);
        b_dpr_user_inst.op(1'h1, 1'h0, 1'h0, 14'hC, 32'h0);
      join
      #1 check({35'h0, col_seen}, 36'h1, "collision");
      @(posedge clk_sys_i) rst_i <= 1'h1;
      @(posedge clk_sys_i) rst_i <= 1'h0;
      #1 check({a_rp, a_rd}, 36'h0, "a reset");
      check({b_rp, b_rd}, 36'h0, "b reset");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    t_rw;
    t_ce;
    t_bw;
    t_en;
    t_ssr;
    t_col;
    conclude;
  end
  initial begin
    #60000;
    error_cnt = error_cnt + 1;
    conclude;
  end
endmodule // dpr_top_tb
